//--- nlaf_pkg.sv
// Package: constants, codes, states and carriers of the NT line activation machine
package nlaf_pkg;

  // Clock rate and time figures in their own units
  localparam int unsigned CLK_HZ        = 100000000; // System clock rate
  localparam int unsigned CLK_MHZ       = 100;       // Same rate in MHz
  localparam int unsigned FRAME_LOST_US = 573000;    // Framing absent time
  localparam int unsigned SIG_SHORT_US  = 3000;      // Short signal loss time
  localparam int unsigned SIG_LONG_US   = 588000;    // Long signal loss time
  localparam int unsigned WAKE_TONE_US  = 9000;      // Wake tone timer
  localparam int unsigned RX_HOLD_US    = 40000;     // Receive reset hold time
  localparam int unsigned TONE_SYM_HZ   = 10000;     // Wake tone symbol rate

  // Derived cycle counts
  localparam int unsigned FRAME_LOST_CYC = FRAME_LOST_US * CLK_MHZ;
  localparam int unsigned SIG_SHORT_CYC  = SIG_SHORT_US * CLK_MHZ;
  localparam int unsigned SIG_LONG_CYC   = SIG_LONG_US * CLK_MHZ;
  localparam int unsigned WAKE_TONE_CYC  = WAKE_TONE_US * CLK_MHZ;
  localparam int unsigned RX_HOLD_CYC    = RX_HOLD_US * CLK_MHZ;
  localparam int unsigned TONE_SYM_CYC   = CLK_HZ / TONE_SYM_HZ;
  localparam int unsigned PATTERN_FRAMES = 4;        // Frames for block pattern

  // Register map
  localparam logic [7:0] REG_CTRL   = 8'h00;         // Control register
  localparam logic [7:0] REG_STATUS = 8'h04;         // Status register
  localparam int unsigned CTRL_WAKE_EN = 0;          // Accept remote wake tone
  localparam int unsigned CTRL_PD_EN   = 1;          // Allow power-down
  localparam logic [1:0] CTRL_RESET    = 2'h3;       // Control reset value
  localparam int unsigned STAT_STATE   = 0;          // State field, 5 bits
  localparam int unsigned STAT_QUAL    = 8;          // Qualified flags, 3 bits

  // Received control codes
  localparam logic [3:0] CI_TIMING_REQ   = 4'h0;
  localparam logic [3:0] CI_RESET        = 4'h1;
  localparam logic [3:0] CI_SEND_PULSES  = 4'h2;
  localparam logic [3:0] CI_DATA_THROUGH = 4'h3;
  localparam logic [3:0] CI_ERROR_IND    = 4'h6;
  localparam logic [3:0] CI_ACT_REQ      = 4'h8;
  localparam logic [3:0] CI_ACT_REQ_LOOP = 4'hA;
  localparam logic [3:0] CI_ACT_IND      = 4'hC;
  localparam logic [3:0] CI_DEACT_IND    = 4'hF;
  // Issued control codes
  localparam logic [3:0] CI_DEACT_REQ    = 4'h0;
  localparam logic [3:0] CI_POWER_UP     = 4'h7;
  localparam logic [3:0] CI_ACT_IND_LOOP = 4'hE;
  localparam logic [3:0] CI_DEACT_CONF   = 4'hF;

  // Line-side data word: two B channels and D channel
  localparam int unsigned DATA_W = 18;

  // Machine states
  typedef enum logic [4:0] {
    ST_RESET     = 5'h00,
    ST_DEACT     = 5'h01,
    ST_ALERT     = 5'h02,
    ST_ALERT1    = 5'h03,
    ST_EC_TRAIN  = 5'h04,
    ST_EC_TRAIN1 = 5'h05,
    ST_EQ_TRAIN  = 5'h06,
    ST_WAIT_SF   = 5'h07,
    ST_SYNC1     = 5'h08,
    ST_SYNC2     = 5'h09,
    ST_WAIT_ACT  = 5'h0A,
    ST_TRANSP    = 5'h0B,
    ST_ERR_ST    = 5'h0C,
    ST_PEND_DST  = 5'h0D,
    ST_PEND_DU   = 5'h0E,
    ST_PEND_RXR  = 5'h0F,
    ST_RX_RESET  = 5'h10,
    ST_AL_TRAIN  = 5'h11,
    ST_ANA_LOOP  = 5'h12
  } nlaf_state_type;

  // Line signal selection
  typedef enum logic [2:0] {
    SIG_SILENT        = 3'h0,
    SIG_WAKE_TONE     = 3'h1,
    SIG_ECHO_TRAIN    = 3'h2,
    SIG_SYNC_NO_SF    = 3'h3,
    SIG_SYNC_M_NORMAL = 3'h4,
    SIG_SYNC_FULL     = 3'h5
  } nlaf_sig_type;

  // Receiver conditions from the line
  typedef struct packed {
    logic frame_aligned;     // Basic frame alignment held
    logic signal_present;    // Receive level present
    logic frame_strobe;      // One pulse per basic frame
    logic frame_all_ones;    // This frame held all ones
    logic frame_all_zeros;   // This frame held all zeros
    logic frame_found;       // Frame found
    logic superframe_found;  // Superframe found
    logic remote_wake_tone;  // Far end wake tone heard
    logic ec_converged;      // Echo canceller converged
  } nlaf_line_type;

  // Overhead bits received from the far end
  typedef struct packed {
    logic act;               // Far end transparency bit
    logic dea;               // Deactivation bit, low starts it
    logic uoa;               // Activate downstream bit
  } nlaf_oh_type;

endpackage

//--- nlaf_top.sv
// Module: NT line activation state machine with condition qualifiers
//
// The Wishbone slave port and the address map were decided locally.
`timescale 1ns/100ps
// Summary of operation
// - framing_lost after 573 ms alignment absent
// - signal_gone_short after 3 ms level absent
// - signal_gone_long after 588 ms loss timer
// - pattern seen after four equal basic frames
// - zeros means remote sync; ones loop sync
// - echo_cancel_converged condition feeds the machine
// - remote wake tone starts an activation
// - downstream B, B, D all ones unless transparent
// - full sync after loop command or transparent
// - request/indication codes, loop variants with command
// - pending deactivation keeps previous transparency bit
// - active bit low for deact or timing codes
// - alerting from deactivated power-up, else confirm
// - alerting sends local wake tone for timer
// - wake tone in receive reset, incomplete: alerting 1
// - loop-back transparent, left by unconditional command
// - power-down only in deactivated state
// - echo training signal, gain/timing/equalizer held
// - echo training 1 when deactivation incomplete
// - wake tone alternates plus/minus three at 10 kHz
// - state timers start at state entry
module nlaf_top
  import nlaf_pkg::*;
#(
  parameter int unsigned FRAME_LOST_N = nlaf_pkg::FRAME_LOST_CYC, // Framing loss cycles
  parameter int unsigned SIG_SHORT_N  = nlaf_pkg::SIG_SHORT_CYC,  // Short loss cycles
  parameter int unsigned SIG_LONG_N   = nlaf_pkg::SIG_LONG_CYC,   // Long loss cycles
  parameter int unsigned WAKE_TONE_N  = nlaf_pkg::WAKE_TONE_CYC,  // Wake tone cycles
  parameter int unsigned RX_HOLD_N    = nlaf_pkg::RX_HOLD_CYC,    // Receive reset hold
  parameter int unsigned TONE_SYM_N   = nlaf_pkg::TONE_SYM_CYC    // Tone symbol cycles
) (
  input  wire logic                         clk_i,         // System clock
  input  wire logic                         rst_i,         // Synchronous reset
  input  wire logic [7:0]                   adr_i,         // Bus byte address
  input  wire logic [31:0]                  dat_i,         // Bus write data
  output logic      [31:0]                  dat_o,         // Bus read data
  input  wire logic                         we_i,          // Bus write enable
  input  wire logic [3:0]                   sel_i,         // Bus byte selects
  input  wire logic                         cyc_i,         // Bus cycle
  input  wire logic                         stb_i,         // Bus strobe
  output logic                              ack_o,         // Bus acknowledge
  input  wire nlaf_pkg::nlaf_line_type      line_i,        // Line conditions
  input  wire nlaf_pkg::nlaf_oh_type        oh_rx_i,       // Received overhead bits
  input  wire logic [3:0]                   ci_rx_i,       // Received control code
  input  wire logic                         loop_cmd_i,    // Loop B channels pulse
  input  wire logic                         return_cmd_i,  // Return to normal pulse
  input  wire logic [nlaf_pkg::DATA_W-1:0]  line_data_i,   // Data from the line
  input  wire logic [nlaf_pkg::DATA_W-1:0]  ds_data_i,     // Data from downstream
  output logic      [nlaf_pkg::DATA_W-1:0]  ds_data_o,     // Data to downstream
  output logic      [nlaf_pkg::DATA_W-1:0]  line_data_o,   // Data to the line
  output nlaf_pkg::nlaf_sig_type            tx_signal_o,   // Line signal selection
  output logic                              tone_plus_o,   // Wake tone symbol sign
  output logic      [3:0]                   ci_tx_o,       // Issued control code
  output logic                              act_bit_o,     // Transparency bit sent
  output logic                              sai_bit_o,     // Downstream active bit
  output logic                              train_hold_o,  // Gain/timing/eq held
  output logic                              power_down_o   // Power-down permitted
);

  import nlaf_pkg::*;

  nlaf_state_type state;         // Present state
  nlaf_state_type next_state;    // Next state
  logic [3:0]     ci_q;          // Registered received code
  logic           loop_mode;     // Loop command in force
  logic           transp_seen;   // Transparent reached this activation
  logic           alert_pu;      // Alerting entered from deactivated
  logic [31:0]    tmr;           // Cycles since state entry
  logic [31:0]    tone_cnt;      // Tone symbol counter
  logic [2:0]     qual;          // framing_lost, short, long
  logic [2:0]     qual_abs;      // Monitored absences
  logic [1:0]     pat_seen;      // ones, zeros pattern seen
  logic [1:0]     pat_hit;       // Frame matched pattern
  logic [1:0]     ctrl;          // Control register
  logic           ec_conv;       // echo_cancel_converged
  logic           framing_lost;  // Qualified framing loss
  logic           signal_gone_short; // Qualified short loss
  logic           signal_gone_long;  // Qualified long loss
  logic           ones_pattern_seen;  // Ones block pattern
  logic           zeros_pattern_seen; // Zeros block pattern
  logic           state_change;  // Next state differs

  localparam int unsigned QUAL_LIM [3] = '{FRAME_LOST_N, SIG_SHORT_N, SIG_LONG_N};

  // Decode for states where the line is synchronised and loss matters
  function automatic logic line_up(input nlaf_state_type s);
    case (s)
      ST_EQ_TRAIN, ST_WAIT_SF, ST_SYNC1, ST_SYNC2, ST_WAIT_ACT,
      ST_TRANSP, ST_ERR_ST, ST_PEND_DST: line_up = 1'b1;
      default: line_up = 1'b0;
    endcase
  endfunction

  // Decode for states sending a sync signal
  function automatic logic sync_state(input nlaf_state_type s);
    case (s)
      ST_SYNC1, ST_SYNC2, ST_WAIT_ACT, ST_TRANSP, ST_ERR_ST,
      ST_PEND_DST, ST_PEND_DU, ST_ANA_LOOP: sync_state = 1'b1;
      default: sync_state = 1'b0;
    endcase
  endfunction

  // Monitored absences
  assign qual_abs           = {~line_i.signal_present, ~line_i.signal_present, ~line_i.frame_aligned};
  assign framing_lost       = qual[0];
  assign signal_gone_short  = qual[1];
  assign signal_gone_long   = qual[2];
  assign pat_hit            = {line_i.frame_all_ones, line_i.frame_all_zeros};
  assign ones_pattern_seen  = pat_seen[1];
  assign zeros_pattern_seen = pat_seen[0];
  assign state_change       = (next_state != state);

  // Qualification counters, one per condition
  generate
    for (genvar q = 0; q < 3; q++) begin : g_qual
      logic [31:0] cnt; // Cycles of absence
      always_ff @(posedge clk_i) begin
        if (rst_i || !qual_abs[q]) begin
          cnt     <= 32'h0000_0000;
          qual[q] <= 1'b0;
        end else if (cnt >= QUAL_LIM[q] - 1) begin
          qual[q] <= 1'b1;
        end else begin
          cnt <= cnt + 32'h0000_0001;
        end
      end
    end
  endgenerate

  // Block pattern detectors over consecutive basic frames
  generate
    for (genvar p = 0; p < 2; p++) begin : g_pat
      logic [2:0] run; // Matching frames in a row
      always_ff @(posedge clk_i) begin
        if (rst_i) begin
          run         <= 3'h0;
          pat_seen[p] <= 1'b0;
        end else if (line_i.frame_strobe) begin
          if (!pat_hit[p]) begin
            run         <= 3'h0;
            pat_seen[p] <= 1'b0;
          end else if (run >= 3'(PATTERN_FRAMES - 1)) begin
            pat_seen[p] <= 1'b1;
          end else begin
            run <= run + 3'h1;
          end
        end
      end
    end
  endgenerate

  // Echo canceller convergence condition
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      ec_conv <= 1'b0;
    end else begin
      ec_conv <= line_i.ec_converged;
    end
  end

  // Received code register
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      ci_q <= CI_DEACT_IND;
    end else begin
      ci_q <= ci_rx_i;
    end
  end

  // Loop history; a loop command beats a return in the same cycle
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      loop_mode <= 1'b0;
    end else if (loop_cmd_i) begin
      loop_mode <= 1'b1;
    end else if (return_cmd_i || state == ST_DEACT || state == ST_RESET) begin
      loop_mode <= 1'b0;
    end
  end

  // Transparent reached during this activation
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      transp_seen <= 1'b0;
    end else if (state == ST_TRANSP) begin
      transp_seen <= 1'b1;
    end else if (state == ST_DEACT || state == ST_RESET || state == ST_RX_RESET) begin
      transp_seen <= 1'b0;
    end
  end

  // State timer, restarted on every entry
  always_ff @(posedge clk_i) begin
    if (rst_i || state_change) begin
      tmr <= 32'h0000_0000;
    end else if (tmr != 32'hFFFF_FFFF) begin
      tmr <= tmr + 32'h0000_0001;
    end
  end

  // Next state
  always_comb begin
    next_state = state;
    case (state)
      ST_RESET: begin
        next_state = (ci_q == CI_ACT_REQ_LOOP) ? ST_AL_TRAIN : ST_DEACT;
      end
      ST_DEACT: begin
        if (ci_q == CI_ACT_REQ_LOOP) begin
          next_state = ST_AL_TRAIN;
        end else if ((line_i.remote_wake_tone && ctrl[CTRL_WAKE_EN]) || ci_q == CI_ACT_REQ) begin
          next_state = ST_ALERT;
        end
      end
      ST_ALERT: begin
        if (tmr >= WAKE_TONE_N - 1) begin
          next_state = ST_EC_TRAIN;
        end
      end
      ST_ALERT1: begin
        if (ci_q == CI_DEACT_IND) begin
          next_state = ST_ALERT;
        end else if (tmr >= WAKE_TONE_N - 1) begin
          next_state = ST_EC_TRAIN1;
        end
      end
      ST_EC_TRAIN: begin
        if (ec_conv) begin
          next_state = ST_EQ_TRAIN;
        end
      end
      ST_EC_TRAIN1: begin
        if (ci_q == CI_DEACT_IND) begin
          next_state = ST_EC_TRAIN;
        end
      end
      ST_EQ_TRAIN: begin
        if (line_i.frame_found) begin
          next_state = ST_WAIT_SF;
        end
      end
      ST_WAIT_SF: begin
        if (line_i.superframe_found && zeros_pattern_seen) begin
          next_state = ST_SYNC1;
        end
      end
      ST_SYNC1: begin
        if (oh_rx_i.uoa) begin
          next_state = ST_SYNC2;
        end
      end
      ST_SYNC2: begin
        if (ci_q == CI_ACT_IND) begin
          next_state = ST_WAIT_ACT;
        end
      end
      ST_WAIT_ACT: begin
        if (oh_rx_i.act) begin
          next_state = ST_TRANSP;
        end
      end
      ST_TRANSP: begin
        if (!oh_rx_i.uoa) begin
          next_state = ST_PEND_DST;
        end else if (ci_q == CI_ERROR_IND) begin
          next_state = ST_ERR_ST;
        end
      end
      ST_ERR_ST: begin
        if (ci_q == CI_ACT_IND) begin
          next_state = ST_WAIT_ACT;
        end
      end
      ST_PEND_DST: begin
        if (ci_q == CI_DEACT_IND) begin
          next_state = ST_SYNC1;
        end
      end
      ST_PEND_DU, ST_PEND_RXR: begin
        if (signal_gone_short) begin
          next_state = ST_RX_RESET;
        end
      end
      ST_RX_RESET: begin
        if (line_i.remote_wake_tone && ctrl[CTRL_WAKE_EN]) begin
          next_state = (ci_q == CI_DEACT_IND) ? ST_ALERT : ST_ALERT1;
        end else if (tmr >= RX_HOLD_N - 1 && ci_q == CI_DEACT_IND) begin
          next_state = ST_DEACT;
        end
      end
      ST_AL_TRAIN: begin
        if (ones_pattern_seen) begin
          next_state = ST_ANA_LOOP;
        end
      end
      ST_ANA_LOOP: begin
        next_state = ST_ANA_LOOP;
      end
      default: begin
        next_state = ST_RESET;
      end
    endcase
    // Far end starts deactivation
    if (state >= ST_SYNC1 && state <= ST_PEND_DST && !oh_rx_i.dea) begin
      next_state = ST_PEND_DU;
    end
    // Unexpected loss while synchronised
    if (line_up(state) && (framing_lost || signal_gone_long)) begin
      next_state = ST_PEND_RXR;
    end
    // Unconditional commands win over everything
    if (ci_q == CI_RESET || ci_q == CI_SEND_PULSES) begin
      next_state = ST_RESET;
    end else if (ci_q == CI_DATA_THROUGH) begin
      next_state = ST_TRANSP;
    end
  end

  // State register and alerting entry origin
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      state    <= ST_RESET;
      alert_pu <= 1'b0;
    end else begin
      state <= next_state;
      if (next_state == ST_ALERT && state != ST_ALERT) begin
        alert_pu <= (state == ST_DEACT);
      end
    end
  end

  // Wake tone symbol alternation
  always_ff @(posedge clk_i) begin
    if (rst_i || (state != ST_ALERT && state != ST_ALERT1)) begin
      tone_cnt    <= 32'h0000_0000;
      tone_plus_o <= 1'b1;
    end else if (tone_cnt >= TONE_SYM_N - 1) begin
      tone_cnt    <= 32'h0000_0000;
      tone_plus_o <= ~tone_plus_o;
    end else begin
      tone_cnt <= tone_cnt + 32'h0000_0001;
    end
  end

  // Line signal selection
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      tx_signal_o <= SIG_SILENT;
    end else if (state == ST_ALERT || state == ST_ALERT1) begin
      tx_signal_o <= SIG_WAKE_TONE;
    end else if (state == ST_EC_TRAIN || state == ST_EC_TRAIN1 || state == ST_AL_TRAIN) begin
      tx_signal_o <= SIG_ECHO_TRAIN;
    end else if (state == ST_WAIT_SF) begin
      tx_signal_o <= SIG_SYNC_NO_SF;
    end else if (sync_state(state)) begin
      tx_signal_o <= (loop_mode || transp_seen || state == ST_TRANSP) ?
                     SIG_SYNC_FULL : SIG_SYNC_M_NORMAL;
    end else begin
      tx_signal_o <= SIG_SILENT;
    end
  end

  // Issued control code
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      ci_tx_o <= CI_DEACT_CONF;
    end else begin
      case (state)
        ST_ALERT:    ci_tx_o <= alert_pu ? CI_POWER_UP : CI_DEACT_CONF;
        ST_SYNC2,
        ST_WAIT_ACT,
        ST_ERR_ST:   ci_tx_o <= loop_mode ? CI_ACT_REQ_LOOP : CI_ACT_REQ;
        ST_TRANSP:   ci_tx_o <= loop_mode ? CI_ACT_IND_LOOP : CI_ACT_IND;
        ST_ANA_LOOP: ci_tx_o <= CI_ACT_IND_LOOP;
        ST_PEND_DST: ci_tx_o <= CI_DEACT_REQ;
        ST_PEND_RXR: ci_tx_o <= CI_ERROR_IND;
        default:     ci_tx_o <= CI_DEACT_CONF;
      endcase
    end
  end

  // Overhead bits
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      act_bit_o <= 1'b0;
      sai_bit_o <= 1'b0;
    end else begin
      sai_bit_o <= !(ci_q == CI_DEACT_IND || ci_q == CI_TIMING_REQ);
      if (state == ST_PEND_DST || state == ST_PEND_DU) begin
        act_bit_o <= act_bit_o;
      end else begin
        act_bit_o <= (state == ST_WAIT_ACT || state == ST_TRANSP || state == ST_ANA_LOOP);
      end
    end
  end

  // Data paths, ones outside the transparent states
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      ds_data_o   <= {DATA_W{1'b1}};
      line_data_o <= {DATA_W{1'b1}};
    end else if (state == ST_TRANSP || state == ST_ANA_LOOP) begin
      ds_data_o   <= line_data_i;
      line_data_o <= ds_data_i;
    end else begin
      ds_data_o   <= {DATA_W{1'b1}};
      line_data_o <= {DATA_W{1'b1}};
    end
  end

  // Training hold and power-down permission
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      train_hold_o <= 1'b0;
      power_down_o <= 1'b0;
    end else begin
      train_hold_o <= (state == ST_EC_TRAIN || state == ST_EC_TRAIN1 || state == ST_AL_TRAIN);
      power_down_o <= (state == ST_DEACT) && (ci_q == CI_DEACT_IND) && ctrl[CTRL_PD_EN];
    end
  end

  // Bus slave: one wait state, then ack for one cycle
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      ack_o <= 1'b0;
      dat_o <= 32'h0000_0000;
      ctrl  <= CTRL_RESET;
    end else begin
      ack_o <= cyc_i && stb_i && !ack_o;
      if (cyc_i && stb_i && !ack_o) begin
        if (we_i && sel_i[0] && adr_i == REG_CTRL) begin
          ctrl <= dat_i[1:0];
        end
        case (adr_i)
          REG_CTRL:   dat_o <= {30'h0000_0000, ctrl};
          REG_STATUS: dat_o <= {16'h0000, transp_seen, loop_mode, ec_conv, pat_seen, qual, 3'h0, state};
          default:    dat_o <= 32'h0000_0000;
        endcase
      end
    end
  end

endmodule

//--- nlaf_assertions.sv
// Checker: port-level assertions of the NT line activation block
`timescale 1ns/100ps
module nlaf_assertions
  import nlaf_pkg::*;
#(
  parameter int unsigned WAKE_TONE_N = 30, // Wake tone cycles
  parameter int unsigned TONE_SYM_N  = 4   // Tone symbol cycles
) (
  input wire logic                  clk_i,        // Clock
  input wire logic                  rst_i,        // Reset
  input wire logic                  cyc_i,        // Bus cycle
  input wire logic                  stb_i,        // Bus strobe
  input wire logic                  ack_o,        // Bus acknowledge
  input wire logic [3:0]            ci_rx_i,      // Received code
  input wire logic [DATA_W-1:0]     ds_data_o,    // Downstream data
  input wire nlaf_pkg::nlaf_sig_type tx_signal_o, // Line signal
  input wire logic                  tone_plus_o,  // Tone sign
  input wire logic                  sai_bit_o,    // Active bit
  input wire logic                  power_down_o, // Power-down
  input wire logic                  train_hold_o  // Training hold
);
  default clocking @(posedge clk_i); endclocking
  default disable iff (rst_i);
  int unsigned wk_n = 0; // Wake tone run length
  int unsigned tn_n = 0; // Cycles since tone sign change
  // Run-length counters for tone timing
  always_ff @(posedge clk_i) begin
    wk_n <= (tx_signal_o == SIG_WAKE_TONE) ? wk_n + 1 : 0;
    tn_n <= ($changed(tone_plus_o) || tx_signal_o != SIG_WAKE_TONE) ? 0 : tn_n + 1;
  end
  sequence s_ci_di; ci_rx_i == CI_DEACT_IND [*4]; endsequence
  sequence s_ci_ar; ci_rx_i == CI_ACT_IND [*4]; endsequence
  property p_ack_resp; cyc_i && stb_i && !ack_o |=> ack_o; endproperty
  property p_ack_pulse; ack_o |=> !ack_o; endproperty
  property p_ds_ones;
    tx_signal_o inside {SIG_SILENT, SIG_WAKE_TONE, SIG_ECHO_TRAIN} |-> ds_data_o == '1;
  endproperty
  property p_sai_off; s_ci_di |-> !sai_bit_o; endproperty
  property p_sai_on; s_ci_ar |-> sai_bit_o; endproperty
  property p_pd; power_down_o |-> tx_signal_o == SIG_SILENT; endproperty
  property p_tone_idle; (tx_signal_o != SIG_WAKE_TONE) [*2] |-> tone_plus_o; endproperty
  property p_tone_rate; tx_signal_o == SIG_WAKE_TONE |-> tn_n < TONE_SYM_N + 1; endproperty
  property p_wake_len; wk_n <= WAKE_TONE_N + 1; endproperty
  property p_hold; tx_signal_o == SIG_ECHO_TRAIN |-> train_hold_o; endproperty
  a_ack_resp: assert property (p_ack_resp) else $error("no ack");
  a_ack_pulse: assert property (p_ack_pulse) else $error("ack too long");
  a_ds_ones: assert property (p_ds_ones) else $error("data not ones");
  a_sai_off: assert property (p_sai_off) else $error("active bit high");
  a_sai_on: assert property (p_sai_on) else $error("active bit low");
  a_pd: assert property (p_pd) else $error("power-down outside idle");
  a_tone_idle: assert property (p_tone_idle) else $error("tone sign idle");
  a_tone_rate: assert property (p_tone_rate) else $error("tone rate");
  a_wake_len: assert property (p_wake_len) else $error("wake tone long");
  a_hold: assert property (p_hold) else $error("training not held");
endmodule

//--- nlaf_far_end.sv
// Far-end line termination model giving receiver conditions
`timescale 1ns/100ps
module nlaf_far_end
  import nlaf_pkg::*;
(
  input  wire logic              clk_i,  // Clock
  input  wire logic              up_i,   // Far end transmitting
  input  wire logic              wake_i, // Far end wake tone
  output nlaf_pkg::nlaf_line_type line_o // Receiver conditions
);
  logic [2:0] div = 3'h0; // Basic frame divider
  // Frame pulse every eight cycles
  always_ff @(posedge clk_i) div <= div + 3'h1;
  // Sync signal carries all-zero frames while up
  assign line_o = '{up_i, up_i, div == 3'h7, 1'b0, up_i, up_i, up_i, wake_i, up_i};
endmodule

//--- testbench.sv
// Testbench: registers, wake-up walk and loss of signal
`timescale 1ns/100ps
`define CHK(a, b) begin cmp_count++; if ((a) !== (b)) begin err_total++; $display("MISMATCH %0t bad value", $time); end end
`define WAITF(c) begin while (!(c)) @(posedge clk_i); end
module testbench;
  import nlaf_pkg::*;
  typedef struct packed { logic [7:0] a; logic w; logic [31:0] d, m, e; } nlaf_row_type;
  logic              clk_i = 1'b0, rst_i = 1'b1, we_i = 1'b0, cyc_i = 1'b0, stb_i = 1'b0;
  logic              loop_cmd_i = 1'b0, return_cmd_i = 1'b0, up = 1'b0, wake = 1'b0;
  logic              ack_o, tone_plus_o, act_bit_o, sai_bit_o, train_hold_o, power_down_o;
  logic [7:0]        adr_i = 8'h00;
  logic [3:0]        ci_rx_i = CI_DEACT_IND, ci_tx_o, sel_i = 4'hf;
  logic [31:0]       dat_i = 32'h0000_0000, dat_o, q;
  logic [DATA_W-1:0] ds_data_o, line_data_o, line_data_i = 18'h2_a5c3, ds_data_i = 18'h1_5a3c;
  nlaf_line_type     line_i;
  nlaf_oh_type       oh_rx_i = 3'b011; // act low, dea high, uoa high
  nlaf_sig_type      tx_signal_o;
  int                err_total = 0, cmp_count = 0, cyc_n = 0;
  nlaf_row_type rows [5] = '{'{8'h00, 1'b0, 32'h0, 32'h3, 32'h3}, '{8'h00, 1'b1, 32'h2, 32'h3, 32'h2},
    '{8'h00, 1'b1, 32'h3, 32'h3, 32'h3}, '{8'h08, 1'b1, 32'hffff_ffff, 32'hffff_ffff, 32'h0},
    '{8'h04, 1'b1, 32'hffff_ffff, 32'h0000_00ff, 32'h0000_0001}};
  nlaf_top #(.FRAME_LOST_N(40), .SIG_SHORT_N(8), .SIG_LONG_N(60), .WAKE_TONE_N(30), .RX_HOLD_N(20),
    .TONE_SYM_N(4)) dut_u (.clk_i, .rst_i, .adr_i, .dat_i, .dat_o, .we_i, .sel_i, .cyc_i,
    .stb_i, .ack_o, .line_i, .oh_rx_i, .ci_rx_i, .loop_cmd_i, .return_cmd_i,
    .line_data_i, .ds_data_i, .ds_data_o, .line_data_o, .tx_signal_o,
    .tone_plus_o, .ci_tx_o, .act_bit_o, .sai_bit_o, .train_hold_o, .power_down_o);
  nlaf_far_end far_u (.clk_i, .up_i(up), .wake_i(wake), .line_o(line_i));
  initial forever #5 clk_i = ~clk_i;
  // Run ceiling
  always @(posedge clk_i) begin
    cyc_n++;
    if (cyc_n > 20000) begin
      err_total++;
      close_out();
    end
  end
  task automatic close_out;
    $display("Checks %0d, mismatches %0d", cmp_count, err_total);
    if (err_total == 0 && cmp_count > 0)
      $display("== PASSED ==");
    else
      $display("== FAILED ==");
    $finish;
  endtask
  // Wishbone single cycle; request held until ack
  task automatic wb(input logic [7:0] a, input logic w, input logic [31:0] d, output logic [31:0] r);
    adr_i <= a; we_i <= w; dat_i <= d; cyc_i <= 1'b1; stb_i <= 1'b1;
    do @(posedge clk_i); while (ack_o !== 1'b1);
    r = dat_o;
    cyc_i <= 1'b0; stb_i <= 1'b0;
    @(posedge clk_i);
  endtask
  initial begin
    repeat (5) @(posedge clk_i);
    rst_i <= 1'b0;
    repeat (4) @(posedge clk_i);
    `CHK(tone_plus_o, 1'b1)
    `CHK(ds_data_o, 18'h3_ffff)
    `CHK(power_down_o, 1'b1)
    foreach (rows[i]) begin
      if (rows[i].w) wb(rows[i].a, 1'b1, rows[i].d, q);
      wb(rows[i].a, 1'b0, 32'h0, q);
      `CHK(q & rows[i].m, rows[i].e)
    end
    sel_i <= 4'he; wb(8'h00, 1'b1, 32'h0, q); sel_i <= 4'hf; wb(8'h00, 1'b0, 32'h0, q);
    `CHK(q[1:0], 2'h3)
    wb(8'h00, 1'b1, 32'h2, q);
    up <= 1'b1; wake <= 1'b1;
    repeat (12) @(posedge clk_i);
    `CHK(tx_signal_o, SIG_SILENT)
    wb(8'h04, 1'b0, 32'h0, q);
    `CHK(q[10:8], 3'b000)
    wb(8'h00, 1'b1, 32'h3, q);
    `WAITF(tx_signal_o == SIG_WAKE_TONE)
    `CHK(ci_tx_o, CI_POWER_UP)
    wake <= 1'b0;
    `WAITF(tx_signal_o == SIG_ECHO_TRAIN)
    `CHK(train_hold_o, 1'b1)
    `WAITF(ci_tx_o == CI_ACT_REQ)
    `CHK(tx_signal_o, SIG_SYNC_M_NORMAL)
    loop_cmd_i <= 1'b1;
    @(posedge clk_i) loop_cmd_i <= 1'b0;
    repeat (4) @(posedge clk_i);
    `CHK(ci_tx_o, CI_ACT_REQ_LOOP)
    `CHK(tx_signal_o, SIG_SYNC_FULL)
    return_cmd_i <= 1'b1;
    @(posedge clk_i) return_cmd_i <= 1'b0;
    repeat (4) @(posedge clk_i);
    `CHK(ci_tx_o, CI_ACT_REQ)
    ci_rx_i <= CI_ACT_IND; oh_rx_i <= 3'b111;
    `WAITF(ci_tx_o == CI_ACT_IND)
    `CHK(tx_signal_o, SIG_SYNC_FULL)
    `CHK(ds_data_o, 18'h2_a5c3)
    `CHK(line_data_o, 18'h1_5a3c)
    `CHK(sai_bit_o, 1'b1)
    oh_rx_i <= 3'b110;
    `WAITF(ds_data_o == 18'h3_ffff)
    `CHK(act_bit_o, 1'b1)
    up <= 1'b0;
    repeat (30) @(posedge clk_i);
    wb(8'h04, 1'b0, 32'h0, q);
    `CHK(q[10:8], 3'b010)
    repeat (40) @(posedge clk_i);
    wb(8'h04, 1'b0, 32'h0, q);
    `CHK(q[10:8], 3'b111)
    ci_rx_i <= CI_DEACT_IND;
    `WAITF(power_down_o == 1'b1)
    `CHK(sai_bit_o, 1'b0)
    close_out();
  end
endmodule
bind nlaf_top nlaf_assertions #(.WAKE_TONE_N(WAKE_TONE_N), .TONE_SYM_N(TONE_SYM_N)) chk_u (.clk_i, .rst_i,
  .cyc_i, .stb_i, .ack_o, .ci_rx_i, .ds_data_o, .tx_signal_o, .tone_plus_o, .sai_bit_o, .power_down_o,
  .train_hold_o);
